// File: design/dlpp_top.sv
// csr bank of the dma front end: bus mode, poll demands, list bases,
// buffer-unavailable status flags
// assumes csr strobes and engine signals come from logic on clk_sys_i
// Operation
// - cache alignment 00 none, 01 8, 10 16, 11 32 longword boundary.
// - a write to transmit poll demand while suspended and no check pending triggers a transmit list check.
// - empty transmit poll resuspends without setting transmit unavailable.
// - transmit poll finding a descriptor resumes the transmit process.
// - transmit poll counts only while transmit process is suspended.
// - a write to receive poll demand while suspended and no check pending triggers a receive descriptor check.
// - empty receive poll resuspends without setting receive unavailable.
// - receive poll finding a descriptor resumes the receive process.
// - receive poll counts only while receive process is suspended.
// - list base registers hold list start address in bits 31:2.
// - status bits 2 and 7 untouched by poll resuspension.
module dlpp_top
  import dlpp_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  input  wire logic        csr_wr_i,
  input  wire logic        csr_rd_i,
  input  wire logic [7:0]  csr_addr_i,
  input  wire logic [31:0] csr_wdata_i,
  output logic [31:0]      csr_rdata_o,
  output logic             csr_ack_o,
  input  wire logic [1:0]  tx_state_i,
  input  wire logic [1:0]  rx_state_i,
  input  wire logic        tx_rsp_valid_i,
  input  wire logic        tx_rsp_avail_i,
  input  wire logic        rx_rsp_valid_i,
  input  wire logic        rx_rsp_avail_i,
  input  wire logic        tbu_event_i,
  input  wire logic        rbu_event_i,
  output logic             tx_poll_trigger_o,
  output logic             rx_poll_trigger_o,
  output logic             tx_resume_o,
  output logic             tx_resuspend_o,
  output logic             rx_resume_o,
  output logic             rx_resuspend_o,
  output logic [31:0]      bus_mode_o,
  output logic [5:0]       cal_boundary_o,
  output logic [31:0]      rx_list_base_o,
  output logic [31:0]      tx_list_base_o
);

  // ****************************************
  // state
  // ****************************************
  logic [31:0] bm_reg;
  logic [31:0] bm_next;
  logic [5:0]  bnd_reg;
  logic [5:0]  bnd_next;
  logic        tbu_reg;
  logic        tbu_next;
  logic        rbu_reg;
  logic        rbu_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        ack_reg;
  logic        ack_next;

  logic        wr_bm;
  logic        wr_txp;
  logic        wr_rxp;
  logic        wr_rxb;
  logic        wr_txb;
  logic        wr_st;
  logic        tx_busy;
  logic        rx_busy;

  // ****************************************
  // write decode
  // ****************************************
  assign wr_bm  = csr_wr_i && (csr_addr_i == OFF_BUS_MODE);
  assign wr_txp = csr_wr_i && (csr_addr_i == OFF_TX_POLL);
  assign wr_rxp = csr_wr_i && (csr_addr_i == OFF_RX_POLL);
  assign wr_rxb = csr_wr_i && (csr_addr_i == OFF_RX_BASE);
  assign wr_txb = csr_wr_i && (csr_addr_i == OFF_TX_BASE);
  assign wr_st  = csr_wr_i && (csr_addr_i == OFF_STATUS);

  // ****************************************
  // bus mode and cache alignment
  // ****************************************
  // writes taken at any time: the host keeps processes stopped
  always_comb
  begin
    bm_next = bm_reg;
    if (wr_bm)
    begin
      bm_next = csr_wdata_i;
    end
    case (bm_next[CAL_HI:CAL_LO])
      CAL_NONE: bnd_next = BND_NONE;
      CAL_8:    bnd_next = BND_8;
      CAL_16:   bnd_next = BND_16;
      CAL_32:   bnd_next = BND_32;
      default:  bnd_next = BND_NONE;
    endcase
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      bm_reg  <= BUS_MODE_RST;
      bnd_reg <= BND_NONE;
    end
    else
    begin
      bm_reg  <= bm_next;
      bnd_reg <= bnd_next;
    end
  end

  assign bus_mode_o     = bm_reg;
  assign cal_boundary_o = bnd_reg;

  // ****************************************
  // buffer-unavailable flags
  // ****************************************
  // set wins over a write-one clear in the same cycle
  always_comb
  begin
    tbu_next = tbu_reg;
    rbu_next = rbu_reg;
    if (wr_st && csr_wdata_i[TBU_BIT])
    begin
      tbu_next = 1'b0;
    end
    if (wr_st && csr_wdata_i[RBU_BIT])
    begin
      rbu_next = 1'b0;
    end
    // only engine fetch misses set these
    if (tbu_event_i)
    begin
      tbu_next = 1'b1;
    end
    if (rbu_event_i)
    begin
      rbu_next = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      tbu_reg <= 1'b0;
      rbu_reg <= 1'b0;
    end
    else
    begin
      tbu_reg <= tbu_next;
      rbu_reg <= rbu_next;
    end
  end

  // ****************************************
  // read path
  // ****************************************
  always_comb
  begin
    rdata_next = rdata_reg;
    ack_next   = csr_wr_i || csr_rd_i;
    if (csr_rd_i)
    begin
      case (csr_addr_i)
        OFF_BUS_MODE: rdata_next = bm_reg;
        OFF_TX_POLL:  rdata_next = POLL_RD_VAL;
        OFF_RX_POLL:  rdata_next = POLL_RD_VAL;
        OFF_RX_BASE:  rdata_next = rx_list_base_o;
        OFF_TX_BASE:  rdata_next = tx_list_base_o;
        OFF_STATUS:
        begin
          rdata_next                      = 32'h00000000;
          rdata_next[TBU_BIT]             = tbu_reg;
          rdata_next[RBU_BIT]             = rbu_reg;
          rdata_next[TS_LO+1:TS_LO]       = tx_state_i;
          rdata_next[RS_LO+1:RS_LO]       = rx_state_i;
        end
        default:      rdata_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      rdata_reg <= 32'h00000000;
      ack_reg   <= 1'b0;
    end
    else
    begin
      rdata_reg <= rdata_next;
      ack_reg   <= ack_next;
    end
  end

  assign csr_rdata_o = rdata_reg;
  assign csr_ack_o   = ack_reg;

  // ****************************************
  // poll handlers and list bases
  // ****************************************
  // transmit poll gating
  dlpp_poll u_tx_poll (
    .clk_sys_i   (clk_sys_i),
    .rst_n_i     (rst_n_i),
    .demand_i    (wr_txp),
    .state_i     (tx_state_i),
    .rsp_valid_i (tx_rsp_valid_i),
    .rsp_avail_i (tx_rsp_avail_i),
    .check_o     (tx_poll_trigger_o),
    .resume_o    (tx_resume_o),
    .resuspend_o (tx_resuspend_o),
    .busy_o      (tx_busy)
  );

  dlpp_poll u_rx_poll (
    .clk_sys_i   (clk_sys_i),
    .rst_n_i     (rst_n_i),
    .demand_i    (wr_rxp),
    .state_i     (rx_state_i),
    .rsp_valid_i (rx_rsp_valid_i),
    .rsp_avail_i (rx_rsp_avail_i),
    .check_o     (rx_poll_trigger_o),
    .resume_o    (rx_resume_o),
    .resuspend_o (rx_resuspend_o),
    .busy_o      (rx_busy)
  );

  dlpp_base u_rx_base (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .wr_i      (wr_rxb),
    .wdata_i   (csr_wdata_i),
    .base_o    (rx_list_base_o)
  );

  dlpp_base u_tx_base (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .wr_i      (wr_txb),
    .wdata_i   (csr_wdata_i),
    .base_o    (tx_list_base_o)
  );

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  a_bm_load: assert property (
    wr_bm |=> bus_mode_o == $past(csr_wdata_i))
    else $error("bus mode write lost");
  a_cal_8: assert property (
    bus_mode_o[15:14] == 2'h1 |-> cal_boundary_o == 6'h08)
    else $error("cal 01 not 8 longwords");
  a_cal_map: assert property (
    bus_mode_o[15:14] == 2'h3 |-> cal_boundary_o == 6'h20)
    else $error("cal 11 not 32 longwords");
  a_cal_none: assert property (
    bus_mode_o[15:14] == 2'h0 |-> cal_boundary_o == 6'h00)
    else $error("cal 00 not unaligned");
  a_rx_ignored: assert property (
    wr_rxp && rx_state_i != PROC_SUSPENDED && !rx_busy |=> !rx_poll_trigger_o)
    else $error("receive poll taken outside suspended");
  a_rx_taken: assert property (
    wr_rxp && rx_state_i == PROC_SUSPENDED && !rx_busy |=> rx_poll_trigger_o)
    else $error("receive poll not checked");
  a_rx_resume: assert property (
    rx_busy && rx_rsp_valid_i && rx_rsp_avail_i |=> rx_resume_o)
    else $error("receive did not resume");
  a_rx_resusp: assert property (
    rx_busy && rx_rsp_valid_i && !rx_rsp_avail_i |=> rx_resuspend_o)
    else $error("receive did not resuspend");
  a_tbu_keep: assert property (
    !tbu_event_i && !wr_st |=> $stable(tbu_reg))
    else $error("transmit unavailable changed by poll");
  a_rbu_keep: assert property (
    !rbu_event_i && !wr_st |=> $stable(rbu_reg))
    else $error("receive unavailable changed by poll");
  a_tbu_win: assert property (
    tbu_event_i |=> tbu_reg)
    else $error("transmit unavailable set lost");
  a_rx_base: assert property (
    wr_rxb |=> rx_list_base_o == ($past(csr_wdata_i) & 32'hfffffffc))
    else $error("receive list base not loaded");
  a_tx_resusp: assert property (
    tx_busy && tx_rsp_valid_i && !tx_rsp_avail_i && !tbu_event_i
    |=> tx_resuspend_o && !$rose(tbu_reg))
    else $error("transmit empty poll set unavailable");

  c_tx_poll: cover property (wr_txp ##1 tx_poll_trigger_o);
  c_rx_resume: cover property (rx_poll_trigger_o ##[1:20] rx_resume_o);
  c_bm_write: cover property (wr_bm ##1 cal_boundary_o == 6'h10);
  c_status_rd: cover property (csr_rd_i && csr_addr_i == OFF_STATUS ##1 csr_ack_o);

endmodule

// File: design/dlpp_pkg.sv
// constants for the dma list-pointer and poll-demand register bank
// assumes byte offsets on the csr access port, 32-bit data
package dlpp_pkg;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] OFF_BUS_MODE  = 8'h00;
  localparam logic [7:0] OFF_TX_POLL   = 8'h08;
  localparam logic [7:0] OFF_RX_POLL   = 8'h10;
  localparam logic [7:0] OFF_RX_BASE   = 8'h18;
  localparam logic [7:0] OFF_TX_BASE   = 8'h20;
  localparam logic [7:0] OFF_STATUS    = 8'h28;

  // ****************************************
  // reset and read values
  // ****************************************
  localparam logic [31:0] BUS_MODE_RST = 32'hfe000000;
  localparam logic [31:0] POLL_RD_VAL  = 32'h0fffffff;
  localparam logic [29:0] BASE_RST     = 30'h00000000;

  // ****************************************
  // field positions
  // ****************************************
  localparam int CAL_HI    = 15;
  localparam int CAL_LO    = 14;
  localparam int TBU_BIT   = 2;
  localparam int RBU_BIT   = 7;
  localparam int TS_LO     = 20;
  localparam int RS_LO     = 17;
  localparam int BASE_LO   = 2;

  // cache alignment codes and burst boundaries in longwords
  localparam logic [1:0] CAL_NONE = 2'h0;
  localparam logic [1:0] CAL_8    = 2'h1;
  localparam logic [1:0] CAL_16   = 2'h2;
  localparam logic [1:0] CAL_32   = 2'h3;
  localparam logic [5:0] BND_NONE = 6'h00;
  localparam logic [5:0] BND_8    = 6'h08;
  localparam logic [5:0] BND_16   = 6'h10;
  localparam logic [5:0] BND_32   = 6'h20;

  // process state codes reported by the descriptor engine
  localparam logic [1:0] PROC_STOPPED   = 2'h0;
  localparam logic [1:0] PROC_RUNNING   = 2'h1;
  localparam logic [1:0] PROC_SUSPENDED = 2'h2;

endpackage

// File: design/dlpp_poll.sv
// poll-demand handler for one direction (transmit or receive)
// assumes the descriptor engine answers a check with rsp_valid_i
module dlpp_poll
  import dlpp_pkg::*;
(
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  input  wire logic       demand_i,
  input  wire logic [1:0] state_i,
  input  wire logic       rsp_valid_i,
  input  wire logic       rsp_avail_i,
  output logic            check_o,
  output logic            resume_o,
  output logic            resuspend_o,
  output logic            busy_o
);

  typedef enum logic {PL_IDLE, PL_CHECK} dlpp_poll_st_t;

  dlpp_poll_st_t st_reg;
  dlpp_poll_st_t st_next;
  logic          chk_reg;
  logic          chk_next;
  logic          res_reg;
  logic          res_next;
  logic          sus_reg;
  logic          sus_next;
  logic          take;

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    st_next  = st_reg;
    chk_next = 1'b0;
    res_next = 1'b0;
    sus_next = 1'b0;
    take     = demand_i && (state_i == PROC_SUSPENDED);
    case (st_reg)
      PL_IDLE:
      begin
        if (take)
        begin
          st_next  = PL_CHECK;
          chk_next = 1'b1;
        end
      end
      PL_CHECK:
      begin
        if (rsp_valid_i)
        begin
          st_next  = PL_IDLE;
          res_next = rsp_avail_i;
          sus_next = !rsp_avail_i;
        end
      end
      default:
      begin
        st_next = PL_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      st_reg  <= PL_IDLE;
      chk_reg <= 1'b0;
      res_reg <= 1'b0;
      sus_reg <= 1'b0;
    end
    else
    begin
      st_reg  <= st_next;
      chk_reg <= chk_next;
      res_reg <= res_next;
      sus_reg <= sus_next;
    end
  end

  assign check_o     = chk_reg;
  assign resume_o    = res_reg;
  assign resuspend_o = sus_reg;
  assign busy_o      = (st_reg == PL_CHECK);

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  a_poll_ignored: assert property (
    demand_i && state_i != PROC_SUSPENDED && !busy_o |=> !check_o)
    else $error("poll taken outside suspended state");
  a_poll_taken: assert property (
    demand_i && state_i == PROC_SUSPENDED && !busy_o |=> check_o ##1 busy_o)
    else $error("poll in suspended state not checked");
  a_poll_resume: assert property (
    busy_o && rsp_valid_i && rsp_avail_i |=> resume_o && !resuspend_o && !busy_o)
    else $error("available descriptor did not resume");
  a_poll_resusp: assert property (
    busy_o && rsp_valid_i && !rsp_avail_i |=> resuspend_o && !resume_o)
    else $error("empty poll did not resuspend");
  c_poll_resume: cover property (check_o ##[1:20] resume_o);
  c_poll_resusp: cover property (check_o ##[1:20] resuspend_o);

endmodule

// File: design/dlpp_base.sv
// descriptor list base address register for one direction
// assumes host writes only while that process is stopped
module dlpp_base
  import dlpp_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  input  wire logic        wr_i,
  input  wire logic [31:0] wdata_i,
  output logic [31:0]      base_o
);

  logic [29:0] base_reg;
  logic [29:0] base_next;

  always_comb
  begin
    base_next = base_reg;
    if (wr_i)
    begin
      base_next = wdata_i[31:BASE_LO];
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      base_reg <= BASE_RST;
    end
    else
    begin
      base_reg <= base_next;
    end
  end

  // low bits forced zero, longword aligned fetches
  assign base_o = {base_reg, 2'h0};

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  a_base_write: assert property (
    wr_i |=> base_o == ($past(wdata_i) & 32'hfffffffc))
    else $error("list base not loaded");
  a_base_hold: assert property (
    !wr_i |=> $stable(base_o))
    else $error("list base changed without write");

endmodule

// File: testbench/dlpp_engine_model.sv
// descriptor engine stand-in for one direction of the dma front end
// assumes the bench loads its state and chooses each check answer
module dlpp_engine_model
  import dlpp_pkg::*;
(
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  input  wire logic       trigger_i,
  input  wire logic       resume_i,
  input  wire logic       resuspend_i,
  input  wire logic       load_i,
  input  wire logic [1:0] state_cfg_i,
  input  wire logic       avail_cfg_i,
  input  wire logic [3:0] delay_i,
  output logic [1:0]      state_o,
  output logic            rsp_valid_o,
  output logic            rsp_avail_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       pend_reg;
  logic [3:0] cnt_reg;
  // avail means nothing outside valid, so show the wrong answer there
  assign rsp_avail_o = rsp_valid_o ? avail_cfg_i : ~avail_cfg_i;
  always_ff @(posedge clk_sys_i)
  begin
    rsp_valid_o <= 1'b0;
    if (!rst_n_i)
    begin
      state_o  <= PROC_STOPPED;
      pend_reg <= 1'b0;
      cnt_reg  <= 4'h0;
    end
    else
    begin
      if (load_i)
        state_o <= state_cfg_i;
      else if (resume_i)
        state_o <= PROC_RUNNING;
      else if (resuspend_i)
        state_o <= PROC_SUSPENDED;
      // answer a check after a chosen delay
      if (trigger_i)
      begin
        pend_reg <= 1'b1;
        cnt_reg  <= delay_i;
      end
      else if (pend_reg && cnt_reg == 4'h0)
      begin
        pend_reg    <= 1'b0;
        rsp_valid_o <= 1'b1;
      end
      else if (pend_reg)
        cnt_reg <= cnt_reg - 4'h1;
    end
  end
endmodule

// File: testbench/dlpp_top_bench.sv
// self-checking bench of the dma csr bank with two engine stand-ins
// assumes a 200 MHz clock and the csr port of dlpp_top
module dlpp_top_bench;
  import dlpp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, bus_mode, rx_base, tx_base;
  logic        ack, tx_rv, tx_ra, rx_rv, rx_ra, tbu_ev = 1'b0, rbu_ev = 1'b0;
  logic        tx_trig, rx_trig, tx_res, tx_sus, rx_res, rx_sus;
  logic [1:0]  tx_st, rx_st, scfg = 2'h0, ld = 2'h0, av = 2'h0;
  logic [1:0]  est [2] = '{2'h0, 2'h0};
  logic [3:0]  dly = 4'h0;
  logic [5:0]  cal_bnd;
  logic        tbu_e = 1'b0, rbu_e = 1'b0;
  logic [31:0] n_trig [2] = '{0, 0}, n_res [2] = '{0, 0}, n_sus [2] = '{0, 0};
  int          n_fail = 0, checks = 0;

  dlpp_top dut_u (.clk_sys_i(clk_sys), .rst_n_i(rst_n), .csr_wr_i(wr), .csr_rd_i(rd),
    .csr_addr_i(addr), .csr_wdata_i(wdata), .csr_rdata_o(rdata), .csr_ack_o(ack),
    .tx_state_i(tx_st), .rx_state_i(rx_st), .tx_rsp_valid_i(tx_rv),
    .tx_rsp_avail_i(tx_ra), .rx_rsp_valid_i(rx_rv), .rx_rsp_avail_i(rx_ra),
    .tbu_event_i(tbu_ev), .rbu_event_i(rbu_ev), .tx_poll_trigger_o(tx_trig),
    .rx_poll_trigger_o(rx_trig), .tx_resume_o(tx_res), .tx_resuspend_o(tx_sus),
    .rx_resume_o(rx_res), .rx_resuspend_o(rx_sus), .bus_mode_o(bus_mode),
    .cal_boundary_o(cal_bnd), .rx_list_base_o(rx_base), .tx_list_base_o(tx_base));
  dlpp_engine_model eng_tx (.clk_sys_i(clk_sys), .rst_n_i(rst_n), .trigger_i(tx_trig),
    .resume_i(tx_res), .resuspend_i(tx_sus), .load_i(ld[0]), .state_cfg_i(scfg),
    .avail_cfg_i(av[0]), .delay_i(dly), .state_o(tx_st), .rsp_valid_o(tx_rv),
    .rsp_avail_o(tx_ra));
  dlpp_engine_model eng_rx (.clk_sys_i(clk_sys), .rst_n_i(rst_n), .trigger_i(rx_trig),
    .resume_i(rx_res), .resuspend_i(rx_sus), .load_i(ld[1]), .state_cfg_i(scfg),
    .avail_cfg_i(av[1]), .delay_i(dly), .state_o(rx_st), .rsp_valid_o(rx_rv),
    .rsp_avail_o(rx_ra));

  initial
  begin
    forever #2.5 clk_sys = ~clk_sys;
  end

  // pulse tallies; skip reset edges, where pulses are still unknown before the first edge
  // after reset an unknown pulse poisons the tally and fails the check
  always @(posedge clk_sys)
  begin
    if (rst_n)
    begin
      n_trig[0] <= n_trig[0] + tx_trig;
      n_trig[1] <= n_trig[1] + rx_trig;
      n_res[0]  <= n_res[0] + tx_res;
      n_res[1]  <= n_res[1] + rx_res;
      n_sus[0]  <= n_sus[0] + tx_sus;
      n_sus[1]  <= n_sus[1] + rx_sus;
    end
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic complete_run();
    if (n_fail == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic csr(input logic r, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    #1 rd = r;
    wr = ~r;
    addr = a;
    wdata = d;
    @(posedge clk_sys);
    #1 rd = 1'b0;
    wr = 1'b0;
    chk({31'h0, ack}, 32'h1);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    csr(1'b1, a, 32'h0);
    chk(rdata, exp);
  endtask

  function automatic logic [31:0] stat_exp();
    return {10'h0, est[0], 1'b0, est[1], 9'h0, rbu_e, 4'h0, tbu_e, 2'h0};
  endfunction

  task automatic set_st(input int i, input logic [1:0] s);
    @(posedge clk_sys);
    #1 ld[i] = 1'b1;
    scfg = s;
    est[i] = s;
    @(posedge clk_sys);
    #1 ld[i] = 1'b0;
  endtask

  task automatic poll(input int i, input logic [1:0] s, input logic a,
                      input logic [31:0] et, input logic [31:0] er, input logic [31:0] es);
    logic [31:0] t0, r0, s0;
    set_st(i, s);
    av[i] = a;
    t0 = n_trig[i];
    r0 = n_res[i];
    s0 = n_sus[i];
    csr(1'b0, i ? OFF_RX_POLL : OFF_TX_POLL, i ? 32'h0 : 32'hffffffff);
    repeat (8 + dly) @(posedge clk_sys);
    #1 chk(n_trig[i] - t0, et);
    chk(n_res[i] - r0, er);
    chk(n_sus[i] - s0, es);
    if (er == 32'h1)
      est[i] = PROC_RUNNING;
    rd_chk(OFF_STATUS, stat_exp());
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    rd_chk(OFF_BUS_MODE, BUS_MODE_RST);
    rd_chk(OFF_TX_POLL, POLL_RD_VAL);
    rd_chk(OFF_RX_POLL, POLL_RD_VAL);
    rd_chk(OFF_RX_BASE, 32'h0);
    rd_chk(OFF_TX_BASE, 32'h0);
    rd_chk(OFF_STATUS, 32'h0);
    rd_chk(8'h30, 32'h0);
    chk({26'h0, cal_bnd}, {26'h0, BND_NONE});
  endtask

  task automatic t_cal();
    logic [5:0]  bnd [4] = '{BND_NONE, BND_8, BND_16, BND_32};
    logic [31:0] d;
    for (int c = 0; c < 4; c++)
    begin
      d = {16'hfe00, 2'(c), 14'h0};
      csr(1'b0, OFF_BUS_MODE, d);
      chk({26'h0, cal_bnd}, {26'h0, bnd[c]});
      chk(bus_mode, d);
      rd_chk(OFF_BUS_MODE, d);
    end
  endtask

  task automatic t_base();
    // bases written with low bits clear
    csr(1'b0, OFF_RX_BASE, 32'h12345678);
    csr(1'b0, OFF_TX_BASE, 32'hfedcba98);
    chk(rx_base, 32'h12345678);
    chk(tx_base, 32'hfedcba98);
    rd_chk(OFF_RX_BASE, 32'h12345678);
    rd_chk(OFF_TX_BASE, 32'hfedcba98);
  endtask

  task automatic t_pending();
    logic [31:0] t0;
    set_st(0, PROC_SUSPENDED);
    dly = 4'h5;
    t0 = n_trig[0];
    csr(1'b0, OFF_TX_POLL, 32'h1);
    csr(1'b0, OFF_TX_POLL, 32'h2);
    repeat (12) @(posedge clk_sys);
    #1 chk(n_trig[0] - t0, 32'h1);
    dly = 4'h0;
  endtask

  task automatic t_flags();
    @(posedge clk_sys);
    #1 tbu_ev = 1'b1;
    rbu_ev = 1'b1;
    @(posedge clk_sys);
    #1 tbu_ev = 1'b0;
    rbu_ev = 1'b0;
    tbu_e = 1'b1;
    rbu_e = 1'b1;
    poll(0, PROC_SUSPENDED, 1'b0, 1, 0, 1);
    poll(1, PROC_SUSPENDED, 1'b0, 1, 0, 1);
    csr(1'b0, OFF_STATUS, 32'h84);
    tbu_e = 1'b0;
    rbu_e = 1'b0;
    rd_chk(OFF_STATUS, stat_exp());
    // set beats a clear that lands in the same cycle
    @(posedge clk_sys);
    #1 wr = 1'b1;
    addr = OFF_STATUS;
    wdata = 32'h84;
    tbu_ev = 1'b1;
    rbu_ev = 1'b1;
    @(posedge clk_sys);
    #1 wr = 1'b0;
    tbu_ev = 1'b0;
    rbu_ev = 1'b0;
    tbu_e = 1'b1;
    rbu_e = 1'b1;
    rd_chk(OFF_STATUS, stat_exp());
  endtask

  task automatic t_rerst();
    @(posedge clk_sys);
    #1 rst_n = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    tbu_e = 1'b0;
    rbu_e = 1'b0;
    t_reset();
  endtask

  initial
  begin
    #200000;
    n_fail++;
    complete_run();
  end

  initial
  begin
    repeat (8) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    t_reset();
    // config while both processes stay stopped
    t_cal();
    t_base();
    for (int i = 0; i < 2; i++)
    begin
      poll(i, PROC_STOPPED, 1'b1, 0, 0, 0);
      poll(i, PROC_RUNNING, 1'b1, 0, 0, 0);
      poll(i, PROC_SUSPENDED, 1'b0, 1, 0, 1);
      dly = 4'h3;
      poll(i, PROC_SUSPENDED, 1'b1, 1, 1, 0);
      dly = 4'h0;
    end
    t_pending();
    t_flags();
    t_rerst();
    complete_run();
  end
endmodule
